// File: gpc_pkg.sv
// Constants shared by the pin configuration block
package gpc_pkg;
   // Pin count and the first of the two upper pins (pins 8 and 9)
   localparam int unsigned NUM_PINS = 12;
   localparam int unsigned UP_LSB   = 8;
   localparam int unsigned UP_W     = 2;

   // Register offsets
   localparam logic [15:0] CFG_OFS   = 16'h01e0;
   localparam logic [15:0] STS_OFS   = 16'h01f0;
   localparam logic [15:0] MSK_OFS   = 16'h01f4;
   localparam logic [15:0] STATE_OFS = 16'h01f8;

   // Field positions of the configuration register
   localparam int unsigned CLR_EN_LSB  = 28;
   localparam int unsigned POL_LSB     = 16;
   localparam int unsigned EVT_OE_LSB  = 14;
   localparam int unsigned EVT_POL_LSB = 12;
   localparam int unsigned BUF_LSB     = 0;

   // Configuration reset value and writable bits
   localparam logic [31:0] CFG_RST   = 32'h0000_3000;
   localparam logic [31:0] CFG_WMASK = 32'h3fff_ffff;

   // Event status layout: pin levels low, timer-clear events above
   localparam int unsigned EVT_W       = 14;
   localparam int unsigned STS_CLR_LSB = 12;
   localparam logic [13:0] EVT_RST     = 14'h0000;

   // Pin state readback layout
   localparam int unsigned STATE_DIR_LSB = 16;

   // Input qualification time, least time rounded up to whole cycles
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned QUAL_TIME_NS  = 40;
   localparam int unsigned QUAL_CYC_RAW  = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned QUAL_CYC      = (QUAL_CYC_RAW < 1) ? 1 : QUAL_CYC_RAW;
endpackage : gpc_pkg

// File: gpc_pin_filter.sv
// Input qualifier: a pin level is taken only after it stays stable
module gpc_pin_filter #(
   parameter int unsigned W          = 12,
   parameter int unsigned STABLE_CYC = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Raw and qualified levels
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] qual
);
   localparam int unsigned CW = $clog2(STABLE_CYC + 1);

   if (STABLE_CYC < 1) begin : g_bad_cyc
      $error("gpc_pin_filter: STABLE_CYC must be at least 1");
   end

   // One stability counter per pin
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;
      logic          lvl_d;
      wire           differ = raw[i] ^ qual[i];
      wire           ripe   = (cnt_q == CW'(STABLE_CYC - 1));

      // Count while the pin differs, accept once ripe
      assign cnt_d = (!differ || ripe) ? '0 : cnt_q + CW'(1);
      assign lvl_d = (differ && ripe) ? raw[i] : qual[i];

      // Counter and accepted level
      always_ff @(posedge clk) begin
         if (rst) begin
            cnt_q   <= '0;
            qual[i] <= 1'b1;  // Idle pins rest high on their pull-ups
         end else begin
            cnt_q   <= cnt_d;
            qual[i] <= lvl_d;
         end
      end
   end
endmodule : gpc_pin_filter

// File: gpc_pin_driver.sv
// Pin driver: open-drain or push-pull output with registered enables
module gpc_pin_driver #(
   parameter int unsigned W = 12
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Drive request
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] drive_en,
   input  wire logic [W-1:0] push_pull,
   // Pin side
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe
);
   logic [W-1:0] out_d;
   logic [W-1:0] oe_d;

   if (W < 1) begin : g_bad_w
      $error("gpc_pin_driver: W must be at least 1");
   end

   // Open-drain pulls low only; push-pull drives both levels
   assign out_d = drive_en & push_pull & value;
   assign oe_d  = drive_en & (push_pull | ~value);

   // Registered pin drive
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else begin
         pin_out <= out_d;
         pin_oe  <= oe_d;
      end
   end
endmodule : gpc_pin_driver

// File: gpc_top.sv
// Pin configuration, event output and timer-clear logic for twelve pins
// Functional notes
// - Enabled upper pin input clears timer flag
// - Clear input active level from pin polarity
// - Timer clear works only on input pins
// - Clear is edge sensitive, short pulses ignored
// - Polarity bit picks level setting pin status
// - Upper pin polarity also sets capture polarity
// - Event enable puts compare events on pin
// - Event enable forces output, buffer type kept
// - Event polarity bits, reset high
// - Buffer bit: 0 open-drain, 1 push-pull
// - Open-drain: low on 0, undriven on 1
// - Open-drain event drive follows event polarity
// - Direction bit: 0 input, 1 output
// - Interrupt inputs level sensitive, qualified first
//
// The plain strobed port was left to the implementer.
module gpc_top #(
   parameter int unsigned QUAL_CYCLES = gpc_pkg::QUAL_CYC
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Register port
   input  wire logic [15:0]                   reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [31:0]                   reg_rdata,
   // Data and direction from the data register
   input  wire logic [gpc_pkg::NUM_PINS-1:0]  pin_data_bits,
   input  wire logic [gpc_pkg::NUM_PINS-1:0]  pin_direction_bits,
   // Pins
   input  wire logic [gpc_pkg::NUM_PINS-1:0]  pin_in,
   output logic      [gpc_pkg::NUM_PINS-1:0]  pin_out,
   output logic      [gpc_pkg::NUM_PINS-1:0]  pin_oe,
   // Time-stamp unit
   input  wire logic [gpc_pkg::UP_W-1:0]      compare_event,
   output logic      [gpc_pkg::UP_W-1:0]      capture_event,
   output logic                               timer_irq_clear,
   // Interrupt
   output logic                               irq
);
   import gpc_pkg::*;

   if (QUAL_CYCLES < 1) begin : g_bad_qual
      $error("gpc_top: QUAL_CYCLES must be at least 1");
   end

   // Place a two-bit upper-pin field at pins 9:8
   function automatic logic [NUM_PINS-1:0] to_upper(input logic [UP_W-1:0] v);
      return NUM_PINS'(v) << UP_LSB;
   endfunction

   logic [31:0]         cfg_q;
   logic [31:0]         cfg_d;
   logic [EVT_W-1:0]    status_q;
   logic [EVT_W-1:0]    status_d;
   logic [EVT_W-1:0]    mask_q;
   logic [EVT_W-1:0]    mask_d;
   logic [31:0]         rdata_d;
   logic [UP_W-1:0]     up_act_q;
   logic [NUM_PINS-1:0] pin_qual;

   // Configuration fields
   wire [UP_W-1:0]     clr_en   = cfg_q[CLR_EN_LSB +: UP_W];
   wire [NUM_PINS-1:0] pin_pol  = cfg_q[POL_LSB +: NUM_PINS];
   wire [UP_W-1:0]     evt_oe   = cfg_q[EVT_OE_LSB +: UP_W];
   wire [UP_W-1:0]     evt_pol  = cfg_q[EVT_POL_LSB +: UP_W];
   wire [NUM_PINS-1:0] buf_type = cfg_q[BUF_LSB +: NUM_PINS];

   // Address decode
   wire hit_cfg   = (reg_addr == CFG_OFS);
   wire hit_sts   = (reg_addr == STS_OFS);
   wire hit_msk   = (reg_addr == MSK_OFS);
   wire hit_state = (reg_addr == STATE_OFS);
   wire wr_cfg    = reg_wr & hit_cfg;
   wire wr_msk    = reg_wr & hit_msk;
   wire rd_sts    = reg_rd & hit_sts;

   wire [NUM_PINS-1:0] eff_dir = pin_direction_bits | to_upper(evt_oe);

   gpc_pin_filter #(
      .W          (NUM_PINS),
      .STABLE_CYC (QUAL_CYCLES)
   ) u_filter (
      .clk  (clk),
      .rst  (rst),
      .raw  (pin_in),
      .qual (pin_qual)
   );

   // Pin active when qualified level matches polarity
   wire [NUM_PINS-1:0] pin_act = ~(pin_qual ^ pin_pol);

   // Capture polarity from the same bits
   wire [UP_W-1:0] up_act = pin_act[UP_LSB +: UP_W];

   // Timer clear on enabled active edge
   // Only while the pin is an input
   wire [UP_W-1:0] clr_edge = up_act & ~up_act_q & clr_en & ~eff_dir[UP_LSB +: UP_W];

   wire [UP_W-1:0] evt_lvl = ~(compare_event ^ evt_pol);

   // Event level replaces data on enabled pins
   wire [NUM_PINS-1:0] drv_val = (pin_data_bits & ~to_upper(evt_oe))
                               | (to_upper(evt_lvl) & to_upper(evt_oe));

   gpc_pin_driver #(
      .W (NUM_PINS)
   ) u_driver (
      .clk       (clk),
      .rst       (rst),
      .value     (drv_val),
      .drive_en  (eff_dir),
      .push_pull (buf_type),
      .pin_out   (pin_out),
      .pin_oe    (pin_oe)
   );

   // Register next values; a new event beats a read clear
   wire [EVT_W-1:0] evt_set = {clr_edge, pin_act};
   assign cfg_d    = wr_cfg ? (reg_wdata & CFG_WMASK) : cfg_q;
   assign mask_d   = wr_msk ? reg_wdata[EVT_W-1:0] : mask_q;
   assign status_d = (rd_sts ? EVT_RST : status_q) | evt_set;

   // Read data selection, unmapped reads give zero
   assign rdata_d = !reg_rd   ? 32'h0000_0000
                  : hit_cfg   ? cfg_q
                  : hit_sts   ? 32'(status_q)
                  : hit_msk   ? 32'(mask_q)
                  : hit_state ? ((32'(eff_dir) << STATE_DIR_LSB) | 32'(pin_qual))
                  : 32'h0000_0000;

   // Configuration, status and mask
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q    <= CFG_RST;
         status_q <= EVT_RST;
         mask_q   <= EVT_RST;
      end else begin
         cfg_q    <= cfg_d;
         status_q <= status_d;
         mask_q   <= mask_d;
      end
   end

   // Registered outputs toward bus, timer unit and interrupt
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata       <= 32'h0000_0000;
         up_act_q        <= '0;
         capture_event   <= '0;
         timer_irq_clear <= 1'b0;
         irq             <= 1'b0;
      end else begin
         reg_rdata       <= rdata_d;
         up_act_q        <= up_act;
         capture_event   <= up_act;
         timer_irq_clear <= |clr_edge;
         irq             <= |(status_d & mask_d);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_clear_disabled: assert property (
      ($past(clr_en) == '0) |-> !timer_irq_clear)
      else $error("timer clear fired while disabled");

   a_clear_input_only: assert property (
      timer_irq_clear |-> ($past(clr_en & ~eff_dir[UP_LSB +: UP_W]) != '0))
      else $error("timer clear fired from an output pin");

   // Clear is a single-cycle edge pulse
   a_clear_edge_pulse: assert property (
      timer_irq_clear |=> !timer_irq_clear)
      else $error("timer clear held for a level");

   // Active level sets status next cycle
   a_status_level: assert property (
      (pin_act != '0) |=> ((status_q[NUM_PINS-1:0] & $past(pin_act)) == $past(pin_act)))
      else $error("active pin level did not set status");

   a_capture_polarity: assert property (
      capture_event == $past(~(pin_qual[UP_LSB +: UP_W] ^ pin_pol[UP_LSB +: UP_W])))
      else $error("capture event polarity wrong");

   a_event_forces_oe: assert property (
      ($past(evt_oe[1]) && $past(buf_type[UP_LSB + 1])) |-> pin_oe[UP_LSB + 1])
      else $error("event pin 9 not driven");

   a_od_never_high: assert property (
      (pin_oe & pin_out & ~$past(buf_type)) == '0)
      else $error("open-drain pin drove high");

   // Open-drain event pin 8 drive state
   a_od_event_drive: assert property (
      ($past(evt_oe[0]) && !$past(buf_type[UP_LSB]))
         |-> (pin_oe[UP_LSB] == ($past(compare_event[0]) ^ $past(evt_pol[0]))))
      else $error("open-drain event drive wrong");

   a_input_undriven: assert property (
      (pin_oe & ~$past(eff_dir)) == '0)
      else $error("input pin driven");

   // Push-pull event level on pin 9
   a_pp_event_level: assert property (
      ($past(evt_oe[1]) && $past(buf_type[UP_LSB + 1]))
         |-> (pin_out[UP_LSB + 1] == ~($past(compare_event[1]) ^ $past(evt_pol[1]))))
      else $error("push-pull event level wrong");

   // Interrupt tracks unmasked status
   a_irq_tracks: assert property (
      irq == ((status_q & mask_q) != '0))
      else $error("interrupt does not match status and mask");

   // Register port checks

   // Read data stand only in the cycle after a read
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> (reg_rdata == 32'h0000_0000))
      else $error("read data outside a read reply");

   // Configuration write lands, reserved bits cleared
   a_cfg_write: assert property (
      $past(wr_cfg) |-> (cfg_q == ($past(reg_wdata) & CFG_WMASK)))
      else $error("configuration write lost");

   // Reserved configuration bits never set
   a_cfg_reserved: assert property (
      (cfg_q & ~CFG_WMASK) == 32'h0000_0000)
      else $error("reserved configuration bit set");

   // Mask write lands in full
   a_mask_write: assert property (
      $past(wr_msk) |-> (mask_q == $past(reg_wdata[EVT_W-1:0])))
      else $error("mask write lost");

   // Read clears status, new events survive
   a_status_rd_clear: assert property (
      $past(rd_sts) |-> (status_q == $past(evt_set)))
      else $error("status read did not clear");

   // Read reply carries status before the clear
   a_status_reply: assert property (
      $past(rd_sts) |-> (reg_rdata == 32'($past(status_q))))
      else $error("status reply wrong");

   // Timer clear is logged in status
   a_clear_logged: assert property (
      timer_irq_clear |-> (status_q[STS_CLR_LSB +: UP_W] != '0))
      else $error("timer clear not logged");

   // Clear only from a pin at its active level
   a_clear_level: assert property (
      timer_irq_clear
         |-> (($past(~(pin_qual[UP_LSB +: UP_W] ^ pin_pol[UP_LSB +: UP_W]))
               & $past(clr_en)) != '0))
      else $error("timer clear without active level");

   a_clear_needs_edge: assert property (
      timer_irq_clear |-> ((~$past(up_act, 2) & $past(up_act) & $past(clr_en)) != '0))
      else $error("timer clear without an edge");

   // Per upper pin checks of the event output path and of timer clear logging
   for (genvar u = 0; u < UP_W; u++) begin : g_up_chk
      localparam int unsigned PN = UP_LSB + u;

      // Event enable drives a push-pull pin
      a_evt_pp_drive: assert property (@(posedge clk) disable iff (rst)
         ($past(evt_oe[u]) && $past(buf_type[PN])) |-> pin_oe[PN])
         else $error("push-pull event pin not driven");

      a_evt_pp_level: assert property (@(posedge clk) disable iff (rst)
         ($past(evt_oe[u]) && $past(buf_type[PN]))
            |-> (pin_out[PN] == ($past(evt_pol[u]) ? $past(compare_event[u])
                                                   : !$past(compare_event[u]))))
         else $error("push-pull event level wrong");

      // Open-drain event pin driven low in one phase
      a_evt_od_state: assert property (@(posedge clk) disable iff (rst)
         ($past(evt_oe[u]) && !$past(buf_type[PN]))
            |-> (!pin_out[PN]
                 && (pin_oe[PN] == ($past(evt_pol[u]) != $past(compare_event[u])))))
         else $error("open-drain event state wrong");

      // Disabled event output leaves data on the pin
      a_evt_off_data: assert property (@(posedge clk) disable iff (rst)
         (!$past(evt_oe[u]) && $past(pin_direction_bits[PN]) && $past(buf_type[PN]))
            |-> (pin_oe[PN] && (pin_out[PN] == $past(pin_data_bits[PN]))))
         else $error("data lost on an event-capable pin");

      // Timer clear logged only from an input pin
      a_clr_from_input: assert property (@(posedge clk) disable iff (rst)
         $rose(status_q[STS_CLR_LSB + u]) |-> !$past(eff_dir[PN]))
         else $error("timer clear logged from an output pin");
   end

   // Pins that carry compare events
   wire [NUM_PINS-1:0] evt_pin = to_upper(evt_oe);

   // Per pin checks of data drive and status
   for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin_chk
      // Push-pull output drives its data bit
      a_pp_data_drive: assert property (@(posedge clk) disable iff (rst)
         ($past(eff_dir[n]) && $past(buf_type[n]) && !$past(evt_pin[n]))
            |-> (pin_oe[n] && (pin_out[n] == $past(pin_data_bits[n]))))
         else $error("push-pull data drive wrong");

      // Open-drain output pulls low on a zero only
      a_od_data_drive: assert property (@(posedge clk) disable iff (rst)
         ($past(eff_dir[n]) && !$past(buf_type[n]) && !$past(evt_pin[n]))
            |-> (!pin_out[n] && (pin_oe[n] == !$past(pin_data_bits[n]))))
         else $error("open-drain data drive wrong");

      // Status rises only on a matching level
      a_status_source: assert property (@(posedge clk) disable iff (rst)
         $rose(status_q[n]) |-> ($past(pin_qual[n]) == $past(pin_pol[n])))
         else $error("status set without matching level");

      a_status_sticky: assert property (@(posedge clk) disable iff (rst)
         (status_q[n] && !rd_sts) |=> status_q[n])
         else $error("status bit lost without a read");
   end
endmodule : gpc_top

// File: gpc_pin_partner.sv
// Far-side model: external source and pull-ups on the pins
module gpc_pin_partner (
   // Device drive
   input  wire logic [gpc_pkg::NUM_PINS-1:0] pin_out,
   input  wire logic [gpc_pkg::NUM_PINS-1:0] pin_oe,
   // External source
   input  wire logic [gpc_pkg::NUM_PINS-1:0] ext_val,
   input  wire logic [gpc_pkg::NUM_PINS-1:0] ext_en,
   // Resolved level
   output logic      [gpc_pkg::NUM_PINS-1:0] pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   import gpc_pkg::*;
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_val));
endmodule // gpc_pin_partner

// File: tb_gpc_top.sv
// Self-checking bench for the pin configuration block
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch %0t %s", $time, m); end end
module tb_gpc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import gpc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic        reg_wr, reg_rd, timer_irq_clear, irq;
   logic [11:0] pin_data_bits, pin_direction_bits, pin_in, pin_out, pin_oe, ext_val, ext_en;
   logic [11:0] b, dr, dt, ed, ev, pl, mk;
   logic [1:0]  compare_event, capture_event, eo, ep;
   int          num_errors, n_tests, p, k, cnt;

   // Clock
   always #25 clk = ~clk;

   gpc_top i_gpc_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_data_bits(pin_data_bits), .pin_direction_bits(pin_direction_bits),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .compare_event(compare_event),
      .capture_event(capture_event), .timer_irq_clear(timer_irq_clear), .irq(irq));
   gpc_pin_partner i_gpc_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));

   // Register bus cycles
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Expected pin value with compare events on pins 9 and 8
   function automatic logic [11:0] drv_val(logic [11:0] d, logic [1:0] o, logic [1:0] q,
                                           logic [1:0] c);
      logic [11:0] v;
      v = d;
      for (int i = 0; i < 2; i++) if (o[i]) v[8+i] = q[i] ? c[i] : ~c[i];
      return v;
   endfunction

   // Hang guard
   initial begin
      #2000000;
      num_errors++;
      $display("mismatch %0t timeout", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pin_data_bits = 12'h000;
      pin_direction_bits = 12'h000;
      compare_event = 2'b00;
      ext_val = 12'h000;
      ext_en = 12'h000;
      void'($urandom(16));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, read-only bits, unmapped place
      rd(CFG_OFS, rv);
      `CHK(rv, 32'h0000_3000, "cfg reset");
      rd(MSK_OFS, rv);
      `CHK(rv, 32'h0, "mask reset");
      rd(STS_OFS, rv);
      `CHK(rv, 32'h0, "status reset");
      `CHK(irq, 1'b0, "irq reset");
      wr(CFG_OFS, 32'hffff_ffff);
      wr(16'h01fc, 32'h0);
      rd(CFG_OFS, rv);
      `CHK(rv, 32'h3fff_ffff, "cfg write");
      rd(16'h01fc, rv);
      `CHK(rv, 32'h0, "unmapped");
      // Drive types, directions, event outputs
      for (int i = 0; i < 12; i++) begin
         b = (i < 4) ? 12'h000 : 12'($urandom);
         eo = (i < 4) ? 2'b11 : 2'($urandom);
         ep = (i < 4) ? 2'(i) : 2'($urandom);
         dr = 12'($urandom);
         dt = 12'($urandom);
         wr(CFG_OFS, {16'h0000, eo, ep, b});
         pin_data_bits <= dt;
         pin_direction_bits <= dr;
         compare_event <= 2'($urandom);
         idle(3);
         ed = dr | {2'b00, eo, 8'h00};
         ev = drv_val(dt, eo, ep, compare_event);
         `CHK(pin_oe, ed & (b | ~ev), "pin enable");
         `CHK(pin_out & b & ed, ev & b & ed, "push-pull");
         `CHK(pin_out & ~b, 12'h000, "open-drain out");
         rd(STATE_OFS, rv);
         `CHK(rv[27:16], ed, "direction");
      end
      // Level status, mask and interrupt
      pin_direction_bits <= 12'h000;
      ext_en <= 12'hfff;
      for (int i = 0; i < 10; i++) begin
         pl = 12'($urandom);
         p = $urandom_range(11, 0);
         mk = (i == 0) ? 12'h000 : 12'($urandom);
         wr(CFG_OFS, {4'h0, pl, 16'h3000});
         ext_val <= ~pl;
         wr(MSK_OFS, {20'h0, mk});
         idle(3);
         rd(STS_OFS, rv);
         rd(STS_OFS, rv);
         `CHK(rv, 32'h0, "quiet status");
         @(posedge clk);
         ext_val[p] <= pl[p];
         idle(4);
         `CHK(irq, mk[p], "irq");
         ext_val[p] <= ~pl[p];
         idle(2);
         rd(STS_OFS, rv);
         `CHK(rv, 32'h1 << p, "status");
         idle(2);
         `CHK(irq, 1'b0, "irq clear");
      end
      // Timer clear on pins 9 and 8
      wr(MSK_OFS, 32'h0);
      pin_data_bits <= 12'hfff;
      for (int j = 0; j < 16; j++) begin
         k = j % 2;
         pl = 12'hfff;
         pl[8+k] = j[1];
         wr(CFG_OFS, {2'b00, 2'(j[2]) << k, pl, 16'h3000});
         ext_val <= ~pl;
         pin_direction_bits <= 12'(j[3]) << (8 + k);
         idle(3);
         rd(STS_OFS, rv);
         `CHK(capture_event[k], 1'b0, "capture idle");
         @(posedge clk);
         ext_val[8+k] <= j[1];
         cnt = 0;
         for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            #1 cnt += (timer_irq_clear === 1'b1);
            if (c == 2)
               `CHK(capture_event[k], 1'b1, "capture");
         end
         `CHK(cnt, (j[2] & ~j[3]) ? 1 : 0, "clear pulses");
         @(posedge clk);
         ext_val[8+k] <= ~j[1];
         idle(3);
         rd(STS_OFS, rv);
         `CHK(rv, (32'h1 << (8 + k)) | (32'(j[2] & ~j[3]) << (12 + k)), "clr sts");
      end
      wrap_up();
   end
endmodule // tb_gpc_top
